// ===== dv/cbs_mem_model.sv
/*
 cbs_mem_model: byte memory on the expanded bus, answering reads at once
 and taking writes at the edge that closes a write cycle.
 Assumes the sequencer's registered bus outputs and one bus cycle a clock.
*/
module cbs_mem_model (
    // clock
    input wire logic clock_i,
    // bus from the sequencer
    input wire logic [15:0] addr_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] data_wr_i,
    // read data back
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] mem [0:65535];
    logic [7:0] last_reg;

    // released bus shows the inverse of the last byte, so a late capture is seen
    assign data_o = !rd_n_i ? mem[addr_i] : ~last_reg;

    initial last_reg = 8'h5A;

    always @(posedge clock_i) begin
        if (!rd_n_i) begin
            last_reg <= mem[addr_i];
        end
        if (!wr_n_i) begin
            mem[addr_i] <= data_wr_i;
        end
    end
endmodule

// ===== dv/cpu_bus_cycle_sequencer_tb.sv
/*
 cpu_bus_cycle_sequencer_tb: directed cycle-by-cycle checks of each instruction.
 Assumes the sequencer, its package and the memory model are compiled first.
*/
module cpu_bus_cycle_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock_i, resetn_i, clk_en_i, start_i, cond_true_i, irq_i, poke;
    cbs_pkg::cbs_op_t op_i;
    logic [15:0] pc_i, sp_i, index_i, addr_o, ret_addr_o;
    logic [7:0] offset_i, cc_i, acc_a_i, acc_b_i, data_i, data_o;
    logic dir_read_o, rd_n_o, wr_n_o, opcode_fetch_indicator_n_o, busy_o, waiting_o;
    int err_count, compares;

    cbs_sequencer cbs_sequencer_i (.clock_i(clock_i), .resetn_i(resetn_i),
        .clk_en_i(clk_en_i), .start_i(start_i), .op_i(op_i), .pc_i(pc_i), .sp_i(sp_i),
        .offset_i(offset_i), .cond_true_i(cond_true_i), .cc_i(cc_i), .acc_a_i(acc_a_i),
        .acc_b_i(acc_b_i), .index_i(index_i), .irq_i(irq_i), .data_i(data_i),
        .addr_o(addr_o), .data_o(data_o), .dir_read_o(dir_read_o), .rd_n_o(rd_n_o),
        .wr_n_o(wr_n_o), .opcode_fetch_indicator_n_o(opcode_fetch_indicator_n_o),
        .busy_o(busy_o), .waiting_o(waiting_o), .ret_addr_o(ret_addr_o));

    cbs_mem_model cbs_mem_model_i (.clock_i(clock_i), .addr_i(addr_o), .rd_n_i(rd_n_o),
        .wr_n_i(wr_n_o), .data_wr_i(data_o), .data_o(data_i));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one bus cycle: optionally advance an edge, then judge at the falling edge
    task automatic cyc(input bit adv, input logic [15:0] a, input cbs_pkg::cbs_kind_t k,
                       input logic [7:0] d);
        if (adv) begin
            @(posedge clock_i);
            start_i <= poke;
            poke = 1'b0;
        end
        @(negedge clock_i);
        chk("addr", addr_o, a);
        chk("dir", 16'(dir_read_o), 16'(k != cbs_pkg::CBS_KIND_WRITE));
        chk("rd_n", 16'(rd_n_o), 16'(k inside {cbs_pkg::CBS_KIND_WRITE,
            cbs_pkg::CBS_KIND_DUMMY}));
        chk("wr_n", 16'(wr_n_o), 16'(k != cbs_pkg::CBS_KIND_WRITE));
        chk("fetch_n", 16'(opcode_fetch_indicator_n_o),
            16'(k != cbs_pkg::CBS_KIND_FETCH));
        if (k == cbs_pkg::CBS_KIND_WRITE) begin
            chk("wdata", 16'(data_o), 16'(d));
        end
    endtask

    task automatic go(input cbs_pkg::cbs_op_t op, input logic [15:0] pc,
                      input logic [15:0] sp, input logic [7:0] off, input logic cond);
        @(posedge clock_i);
        op_i <= op;
        pc_i <= pc;
        sp_i <= sp;
        offset_i <= off;
        cond_true_i <= cond;
        start_i <= 1'b1;
        @(posedge clock_i);
        start_i <= 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while ((busy_o !== 1'b0 || waiting_o !== 1'b0) && n < 50) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 50) begin
            err_count++;
            close_out();
        end
        repeat (2) @(posedge clock_i);
    endtask

    task automatic do_branch(input logic [15:0] pc, input logic [7:0] off, input logic t,
                             input bit stall);
        logic [15:0] dest;
        dest = t ? pc + 16'h0002 + {{8{off[7]}}, off} : pc + 16'h0002;
        go(cbs_pkg::CBS_OP_BRANCH, 16'h0000 + pc, 16'h01FF, off, t);
        cyc(1, pc + 16'h0001, cbs_pkg::CBS_KIND_READ, 8'h00);
        if (stall) begin
            @(posedge clock_i);
            clk_en_i <= 1'b0;
            cyc(0, 16'hFFFF, cbs_pkg::CBS_KIND_DUMMY, 8'h00);
            repeat (3) @(posedge clock_i);
            cyc(0, 16'hFFFF, cbs_pkg::CBS_KIND_DUMMY, 8'h00);
            @(posedge clock_i);
            clk_en_i <= 1'b1;
        end else begin
            cyc(1, 16'hFFFF, cbs_pkg::CBS_KIND_DUMMY, 8'h00);
        end
        cyc(1, dest, cbs_pkg::CBS_KIND_FETCH, 8'h00);
        cyc(1, 16'hFFFF, cbs_pkg::CBS_KIND_DUMMY, 8'h00);
        wait_idle();
    endtask

    // shared opening of the software interrupt and the wait
    task automatic push7(input logic [15:0] pc, input logic [15:0] sp, input bit refuse);
        logic [7:0] b [7];
        logic [15:0] r;
        // the pushed return address is the opcode address plus one, carry included
        r = 16'(pc + 16'h0001);
        b = '{r[7:0], r[15:8], index_i[7:0], index_i[15:8], acc_a_i, acc_b_i, cc_i};
        cyc(1, pc + 16'h0001, cbs_pkg::CBS_KIND_READ, 8'h00);
        cyc(1, 16'hFFFF, cbs_pkg::CBS_KIND_DUMMY, 8'h00);
        for (int i = 0; i < 7; i++) begin
            poke = refuse && (i == 2);
            cyc(1, sp - 16'(i), cbs_pkg::CBS_KIND_WRITE, b[i]);
        end
    endtask

    initial begin
        repeat (5000) @(posedge clock_i);
        err_count++;
        close_out();
    end

    initial begin
        resetn_i = 1'b0;
        clk_en_i = 1'b1;
        start_i = 1'b0;
        poke = 1'b0;
        op_i = cbs_pkg::CBS_OP_SWI;
        pc_i = 16'h0000;
        sp_i = 16'h0000;
        offset_i = 8'h00;
        cond_true_i = 1'b0;
        cc_i = 8'hC5;
        acc_a_i = 8'hA1;
        acc_b_i = 8'hB2;
        index_i = 16'h1234;
        irq_i = 1'b0;
        err_count = 0;
        compares = 0;
        cbs_mem_model_i.mem[16'hFFFA] = 8'h56;
        cbs_mem_model_i.mem[16'hFFFB] = 8'h78;
        for (int i = 1; i < 8; i++) begin
            cbs_mem_model_i.mem[16'h01F0 + 16'(i)] = 8'h10 + 8'(i);
        end
        cbs_mem_model_i.mem[16'h01F6] = 8'h9A;
        repeat (10) @(posedge clock_i);
        resetn_i <= 1'b1;
        cyc(0, 16'hFFFF, cbs_pkg::CBS_KIND_DUMMY, 8'h00);
        chk("busy", 16'(busy_o), 16'h0000);
        do_branch(16'h1000, 8'h05, 1'b1, 1'b1);
        do_branch(16'h2000, 8'h80, 1'b1, 1'b0);
        do_branch(16'h2000, 8'h80, 1'b0, 1'b0);
        // branch to subroutine: return address pushed is pc+2
        go(cbs_pkg::CBS_OP_BSR, 16'h30FF, 16'h01FF, 8'hFE, 1'b0);
        cyc(1, 16'h3100, cbs_pkg::CBS_KIND_READ, 8'h00);
        cyc(1, 16'hFFFF, cbs_pkg::CBS_KIND_DUMMY, 8'h00);
        cyc(1, 16'h01FF, cbs_pkg::CBS_KIND_WRITE, 8'h01);
        cyc(1, 16'h01FE, cbs_pkg::CBS_KIND_WRITE, 8'h31);
        cyc(1, 16'h30FF, cbs_pkg::CBS_KIND_FETCH, 8'h00);
        wait_idle();
        // software interrupt, with a start attempt while it runs
        go(cbs_pkg::CBS_OP_SWI, 16'h40FF, 16'h01FF, 8'h00, 1'b0);
        push7(16'h40FF, 16'h01FF, 1'b1);
        cyc(1, 16'hFFFA, cbs_pkg::CBS_KIND_READ, 8'h00);
        cyc(1, 16'hFFFB, cbs_pkg::CBS_KIND_READ, 8'h00);
        cyc(1, 16'h5678, cbs_pkg::CBS_KIND_FETCH, 8'h00);
        cyc(1, 16'hFFFF, cbs_pkg::CBS_KIND_DUMMY, 8'h00);
        wait_idle();
        // return from interrupt pops seven bytes; the last two form the return
        go(cbs_pkg::CBS_OP_RTI, 16'h5000, 16'h01F0, 8'h00, 1'b0);
        cyc(1, 16'h5001, cbs_pkg::CBS_KIND_READ, 8'h00);
        cyc(1, 16'hFFFF, cbs_pkg::CBS_KIND_DUMMY, 8'h00);
        for (int i = 1; i < 8; i++) begin
            cyc(1, 16'h01F0 + 16'(i), cbs_pkg::CBS_KIND_READ, 8'h00);
        end
        cyc(1, 16'h9A17, cbs_pkg::CBS_KIND_FETCH, 8'h00);
        // the status copy of the return address trails the fetch by one edge
        cyc(1, 16'hFFFF, cbs_pkg::CBS_KIND_DUMMY, 8'h00);
        chk("ret_addr", ret_addr_o, 16'h9A17);
        wait_idle();
        // wait: pushes, then bus stays idle with no vector fetch
        go(cbs_pkg::CBS_OP_WAI, 16'h6000, 16'h01EF, 8'h00, 1'b0);
        push7(16'h6000, 16'h01EF, 1'b0);
        repeat (4) cyc(1, 16'hFFFF, cbs_pkg::CBS_KIND_DUMMY, 8'h00);
        chk("waiting", 16'(waiting_o), 16'h0001);
        @(posedge clock_i);
        irq_i <= 1'b1;
        repeat (3) cyc(1, 16'hFFFF, cbs_pkg::CBS_KIND_DUMMY, 8'h00);
        @(posedge clock_i);
        irq_i <= 1'b0;
        wait_idle();
        close_out();
    end
endmodule

// ===== hw/cbs_cfg.svh
/*
 cbs_cfg.svh: constants of the bus-cycle sequencer (addresses and cycle counts).
 Assumes it is included by bare name from files under hw/.
*/
`ifndef CBS_CFG_SVH
`define CBS_CFG_SVH

`define CBS_DUMMY_ADDR 16'hFFFF
`define CBS_SWI_VEC_HI 16'hFFFA
`define CBS_SWI_CYCLES 4'hC
`define CBS_WAI_CYCLES 4'h9
`define CBS_RTI_CYCLES 4'hA
`define CBS_BR_CYCLES 4'h3
`define CBS_BSR_CYCLES 4'h5

`endif

// ===== hw/cbs_pkg.sv
/*
 cbs_pkg: types of the bus-cycle sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cbs_pkg;
    typedef enum logic [2:0] {
        CBS_OP_SWI,
        CBS_OP_WAI,
        CBS_OP_RTI,
        CBS_OP_BRANCH,
        CBS_OP_BSR
    } cbs_op_t;

    typedef enum logic [1:0] {
        CBS_KIND_READ,
        CBS_KIND_WRITE,
        CBS_KIND_DUMMY,
        CBS_KIND_FETCH
    } cbs_kind_t;
endpackage

// ===== hw/cbs_sequencer.sv
/*
 cbs_sequencer: per-instruction bus-cycle sequencer for the interrupt implied
 instructions and relative branches of an 8-bit core.
 Assumes the core presents a start pulse with operands, one bus cycle per
 clock, and supplies read data on data_i during the read cycle itself.
*/
`include "cbs_cfg.svh"

// Behaviour
// - the software interrupt takes 12 cycles: operand read, dummy at FFFF, seven pushes.
// - after pushing it reads the vector high at FFFA, low at FFFB, then fetches the handler.
// - reads raise direction and lower read, writes the reverse; fetches lower the indicator.
// - return from interrupt takes 10 cycles, reading SP+1..SP+7, then fetches at the return.
// - each conditional branch takes 3 cycles ending in a fetch at target or next opcode.
// - subroutine branch takes 5 cycles: return low at SP, high at SP-1, then target fetch.
module cbs_sequencer (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // instruction start
    input wire logic start_i,
    input wire cbs_pkg::cbs_op_t op_i,
    input wire logic [15:0] pc_i,
    input wire logic [15:0] sp_i,
    input wire logic [7:0] offset_i,
    input wire logic cond_true_i,
    input wire logic [7:0] cc_i,
    input wire logic [7:0] acc_a_i,
    input wire logic [7:0] acc_b_i,
    input wire logic [15:0] index_i,
    input wire logic irq_i,
    // memory read data
    input wire logic [7:0] data_i,
    // bus outputs
    output logic [15:0] addr_o,
    output logic [7:0] data_o,
    output logic dir_read_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic opcode_fetch_indicator_n_o,
    // status
    output logic busy_o,
    output logic waiting_o,
    output logic [15:0] ret_addr_o
);
    typedef enum logic [1:0] {CBS_IDLE, CBS_RUN, CBS_WAIT} cbs_state_t;

    cbs_state_t state_reg;
    cbs_pkg::cbs_op_t op_reg;
    logic [3:0] cycle_reg;
    logic [3:0] last_reg;
    logic taken_reg;
    logic [15:0] pc_reg;
    logic [15:0] sp_reg;
    logic [15:0] target_reg;
    logic [15:0] vector_reg;
    logic [15:0] ret_reg;
    logic [7:0] push_reg [0:6];
    logic [15:0] step_addr;
    cbs_pkg::cbs_kind_t step_kind;
    logic prev_read_reg;
    logic [3:0] prev_cycle_reg;
    logic [15:0] vector_now;
    logic [15:0] ret_now;
    logic [3:0] span_reg;

    function automatic logic [3:0] cycles_of(input cbs_pkg::cbs_op_t op);
        unique case (op)
            cbs_pkg::CBS_OP_SWI: cycles_of = `CBS_SWI_CYCLES;
            cbs_pkg::CBS_OP_WAI: cycles_of = `CBS_WAI_CYCLES;
            cbs_pkg::CBS_OP_RTI: cycles_of = `CBS_RTI_CYCLES;
            cbs_pkg::CBS_OP_BRANCH: cycles_of = `CBS_BR_CYCLES;
            cbs_pkg::CBS_OP_BSR: cycles_of = `CBS_BSR_CYCLES;
            default: cycles_of = `CBS_BR_CYCLES;
        endcase
    endfunction

    // the low byte lands on the edge that launches the fetch, so pass it straight through
    assign vector_now = (prev_read_reg && prev_cycle_reg == 4'hB)
                        ? {vector_reg[15:8], data_i}
                        : vector_reg;
    assign ret_now = (prev_read_reg && prev_cycle_reg == 4'h9)
                     ? {ret_reg[15:8], data_i}
                     : ret_reg;

    cbs_step_decode u_decode (
        .op_i(op_reg),
        .cycle_i(cycle_reg),
        .taken_i(taken_reg),
        .pc_i(pc_reg),
        .sp_i(sp_reg),
        .target_i(target_reg),
        .vector_i(vector_now),
        .ret_i(ret_now),
        .addr_o(step_addr),
        .kind_o(step_kind)
    );

    // sequencing; a start while busy is ignored
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= CBS_IDLE;
            cycle_reg <= 4'h0;
            last_reg <= 4'h0;
            op_reg <= cbs_pkg::CBS_OP_BRANCH;
        end else if (clk_en_i) begin
            unique case (state_reg)
                CBS_IDLE: begin
                    if (start_i) begin
                        state_reg <= CBS_RUN;
                        cycle_reg <= 4'h1;
                        op_reg <= op_i;
                        last_reg <= cycles_of(op_i);
                    end
                end
                CBS_RUN: begin
                    if (cycle_reg == last_reg) begin
                        // wait ends after the last push with no vector fetch
                        state_reg <= (op_reg == cbs_pkg::CBS_OP_WAI) ? CBS_WAIT
                                                                      : CBS_IDLE;
                        cycle_reg <= 4'h0;
                    end else begin
                        cycle_reg <= 4'(cycle_reg + 4'h1);
                    end
                end
                CBS_WAIT: begin
                    if (irq_i) begin
                        state_reg <= CBS_IDLE;
                    end
                end
            endcase
        end
    end

    // operand capture at start
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc_reg <= 16'h0000;
            sp_reg <= 16'h0000;
            target_reg <= 16'h0000;
            taken_reg <= 1'b0;
            for (int i = 0; i < 7; i++) begin
                push_reg[i] <= 8'h00;
            end
        end else if (clk_en_i && state_reg == CBS_IDLE && start_i) begin
            pc_reg <= pc_i;
            sp_reg <= sp_i;
            // branch target is relative to the next opcode, offset sign-extended
            target_reg <= 16'(pc_i + 16'h0002 + {{8{offset_i[7]}}, offset_i});
            taken_reg <= cond_true_i;
            push_reg[0] <= (op_i == cbs_pkg::CBS_OP_BSR) ? 8'(pc_i + 16'h0002)
                                                         : 8'(pc_i + 16'h0001);
            push_reg[1] <= (op_i == cbs_pkg::CBS_OP_BSR) ? 8'((pc_i + 16'h0002) >> 8)
                                                         : 8'((pc_i + 16'h0001) >> 8);
            push_reg[2] <= index_i[7:0];
            push_reg[3] <= index_i[15:8];
            push_reg[4] <= acc_a_i;
            push_reg[5] <= acc_b_i;
            push_reg[6] <= cc_i;
        end
    end

    // read data capture: vector and return address bytes
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vector_reg <= 16'h0000;
            ret_reg <= 16'h0000;
        end else if (clk_en_i && prev_read_reg) begin
            if (op_reg == cbs_pkg::CBS_OP_SWI && prev_cycle_reg == 4'hA) begin
                vector_reg[15:8] <= data_i;
            end
            if (op_reg == cbs_pkg::CBS_OP_SWI && prev_cycle_reg == 4'hB) begin
                vector_reg[7:0] <= data_i;
            end
            if (op_reg == cbs_pkg::CBS_OP_RTI && prev_cycle_reg == 4'h8) begin
                ret_reg[15:8] <= data_i;
            end
            if (op_reg == cbs_pkg::CBS_OP_RTI && prev_cycle_reg == 4'h9) begin
                ret_reg[7:0] <= data_i;
            end
        end
    end

    // bus outputs, registered one cycle behind the step decode
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_o <= `CBS_DUMMY_ADDR;
            data_o <= 8'h00;
            dir_read_o <= 1'b1;
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            opcode_fetch_indicator_n_o <= 1'b1;
            prev_read_reg <= 1'b0;
            prev_cycle_reg <= 4'h0;
        end else if (clk_en_i) begin
            prev_cycle_reg <= cycle_reg;
            if (state_reg == CBS_RUN) begin
                addr_o <= step_addr;
                dir_read_o <= (step_kind != cbs_pkg::CBS_KIND_WRITE);
                rd_n_o <= !(step_kind == cbs_pkg::CBS_KIND_READ
                           || step_kind == cbs_pkg::CBS_KIND_FETCH);
                wr_n_o <= (step_kind != cbs_pkg::CBS_KIND_WRITE);
                opcode_fetch_indicator_n_o <= (step_kind != cbs_pkg::CBS_KIND_FETCH);
                prev_read_reg <= (step_kind == cbs_pkg::CBS_KIND_READ);
                if (step_kind == cbs_pkg::CBS_KIND_WRITE) begin
                    data_o <= push_reg[3'(cycle_reg - 4'h3)];
                end
            end else begin
                // quiet bus between instructions and while waiting
                addr_o <= `CBS_DUMMY_ADDR;
                dir_read_o <= 1'b1;
                rd_n_o <= 1'b1;
                wr_n_o <= 1'b1;
                opcode_fetch_indicator_n_o <= 1'b1;
                prev_read_reg <= 1'b0;
            end
        end
    end

    // enabled cycles spent in the current run; the length checks count on it, not on cycle_reg
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            span_reg <= 4'h0;
        end else if (clk_en_i) begin
            if (state_reg == CBS_IDLE && start_i) begin
                span_reg <= 4'h1;
            end else if (state_reg == CBS_RUN && span_reg != 4'hF) begin
                span_reg <= 4'(span_reg + 4'h1);
            end
        end
    end

    // status
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_o <= 1'b0;
            waiting_o <= 1'b0;
            ret_addr_o <= 16'h0000;
        end else if (clk_en_i) begin
            busy_o <= (state_reg == CBS_RUN);
            waiting_o <= (state_reg == CBS_WAIT);
            ret_addr_o <= ret_reg;
        end
    end

    strobe_excl_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !(!rd_n_o && !wr_n_o)) else $error("read and write strobes both active");
    write_dir_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !wr_n_o |-> !dir_read_o) else $error("write without direction low");
    swi_length_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (clk_en_i && state_reg == CBS_RUN && op_reg == cbs_pkg::CBS_OP_SWI)
        |=> ((state_reg == CBS_RUN) == ($past(span_reg) != `CBS_SWI_CYCLES)))
        else $error("swi length wrong");
    swi_vector_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (clk_en_i && state_reg == CBS_RUN && op_reg == cbs_pkg::CBS_OP_SWI
         && cycle_reg == 4'hA) |=> addr_o == 16'hFFFA && !rd_n_o)
        else $error("vector read not at FFFA");
    rti_length_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (clk_en_i && state_reg == CBS_RUN && op_reg == cbs_pkg::CBS_OP_RTI)
        |=> ((state_reg == CBS_RUN) == ($past(span_reg) != `CBS_RTI_CYCLES)))
        else $error("rti length wrong");
    branch_len_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (clk_en_i && state_reg == CBS_RUN && op_reg == cbs_pkg::CBS_OP_BRANCH)
        |=> ((state_reg == CBS_RUN) == ($past(span_reg) != `CBS_BR_CYCLES)))
        else $error("branch length wrong");
    bsr_push_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (clk_en_i && state_reg == CBS_RUN && op_reg == cbs_pkg::CBS_OP_BSR
         && cycle_reg == 4'h4) |=> !wr_n_o && addr_o == 16'(sp_reg - 16'h0001))
        else $error("bsr high push misplaced");
    wait_idle_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (state_reg == CBS_WAIT && $past(state_reg) == CBS_WAIT) |-> rd_n_o && wr_n_o)
        else $error("bus active while waiting");
endmodule

// ===== hw/cbs_step_decode.sv
/*
 cbs_step_decode: combinational map from instruction and cycle number to the
 address and the kind of bus cycle.
 Assumes the caller holds the operand state steady for the whole instruction.
*/
`include "cbs_cfg.svh"

module cbs_step_decode (
    // selection
    input wire cbs_pkg::cbs_op_t op_i,
    input wire logic [3:0] cycle_i,
    input wire logic taken_i,
    // operand state
    input wire logic [15:0] pc_i,
    input wire logic [15:0] sp_i,
    input wire logic [15:0] target_i,
    input wire logic [15:0] vector_i,
    input wire logic [15:0] ret_i,
    // result
    output logic [15:0] addr_o,
    output cbs_pkg::cbs_kind_t kind_o
);
    function automatic logic [15:0] sp_off(input logic [15:0] sp, input logic [3:0] n,
            input logic up);
        sp_off = up ? 16'(sp + {12'h000, n}) : 16'(sp - {12'h000, n});
    endfunction

    always_comb begin
        addr_o = `CBS_DUMMY_ADDR;
        kind_o = cbs_pkg::CBS_KIND_DUMMY;
        if (cycle_i == 4'h1) begin
            addr_o = 16'(pc_i + 16'h0001);
            kind_o = cbs_pkg::CBS_KIND_READ;
        end else if (cycle_i != 4'h2) begin
            unique case (op_i)
                cbs_pkg::CBS_OP_SWI, cbs_pkg::CBS_OP_WAI: begin
                    if (cycle_i <= 4'h9) begin
                        addr_o = sp_off(sp_i, 4'(cycle_i - 4'h3), 1'b0);
                        kind_o = cbs_pkg::CBS_KIND_WRITE;
                    end else if (cycle_i == 4'hA) begin
                        addr_o = `CBS_SWI_VEC_HI;
                        kind_o = cbs_pkg::CBS_KIND_READ;
                    end else if (cycle_i == 4'hB) begin
                        addr_o = 16'(`CBS_SWI_VEC_HI + 16'h0001);
                        kind_o = cbs_pkg::CBS_KIND_READ;
                    end else begin
                        addr_o = vector_i;
                        kind_o = cbs_pkg::CBS_KIND_FETCH;
                    end
                end
                cbs_pkg::CBS_OP_RTI: begin
                    if (cycle_i <= 4'h9) begin
                        addr_o = sp_off(sp_i, 4'(cycle_i - 4'h2), 1'b1);
                        kind_o = cbs_pkg::CBS_KIND_READ;
                    end else begin
                        addr_o = ret_i;
                        kind_o = cbs_pkg::CBS_KIND_FETCH;
                    end
                end
                cbs_pkg::CBS_OP_BRANCH: begin
                    addr_o = taken_i ? target_i : 16'(pc_i + 16'h0002);
                    kind_o = cbs_pkg::CBS_KIND_FETCH;
                end
                cbs_pkg::CBS_OP_BSR: begin
                    if (cycle_i <= 4'h4) begin
                        addr_o = sp_off(sp_i, 4'(cycle_i - 4'h3), 1'b0);
                        kind_o = cbs_pkg::CBS_KIND_WRITE;
                    end else begin
                        addr_o = target_i;
                        kind_o = cbs_pkg::CBS_KIND_FETCH;
                    end
                end
                default: begin
                    addr_o = `CBS_DUMMY_ADDR;
                    kind_o = cbs_pkg::CBS_KIND_DUMMY;
                end
            endcase
        end
    end
endmodule
